// ---- core/serial_pkg.sv ----
// shared constants, carriers and state types of the serial controller
// assumes one system clock domain plus a receive link clock for channel b
package serial_pkg;

    // ------------------------------------------------------------
    // widths and counts
    // ------------------------------------------------------------
    localparam int WORD_W = 8;
    localparam logic [3:0] RX_BIT_LAST = 4'h8;  // hunt=0, data bits 1..8
    localparam logic [3:0] TX_FRAME_LAST = 4'h9; // start, 8 data, stop
    localparam int FIFO_DEPTH = 2;

    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic LINE_IDLE = 1'b1;       // marking level on line outputs
    localparam logic MODEM_INACTIVE = 1'b1;  // modem outputs inactive high
    localparam logic [3:0] COUNT_RESET = 4'h0;
    localparam logic [7:0] WORD_RESET = 8'h00;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic async_mode;
        logic auto_enable_a;
        logic auto_enable_b;
        logic rx_enable_a;
        logic rx_enable_b;
        logic tx_enable_b;
        logic rts_a;
        logic rts_b;
    } ctrl_s;

    localparam ctrl_s CTRL_RESET = '0;

    typedef struct packed {
        logic configured;
        logic rx_on_a;
        logic rx_on_b;
        logic tx_busy_b;
        logic rx_overrun_b;
    } status_s;

    localparam status_s STATUS_RESET = '0;

    typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_e;

endpackage : serial_pkg

// ---- core/two_entry_fifo.sv ----
// small valid/ready buffer, parameterised width and depth
// assumes source and sink both on clk; reset synchronous active high
module two_entry_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW:0] FULL_COUNT = (PW + 1)'(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0] wr_q;
    logic [PW-1:0] rd_q;
    logic [PW:0] count_q;
    wire push;
    wire pop;

    // ------------------------------------------------------------
    // handshake decode
    // ------------------------------------------------------------
    assign in_ready = (count_q != FULL_COUNT);
    assign out_valid = (count_q != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_q[rd_q];

    function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
        next_ptr = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
    endfunction : next_ptr

    // storage has no reset; only the pointers and count_q decide what is valid
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // pointers and occupancy
    always_ff @(posedge clk) begin
        if (reset) begin
            wr_q <= '0;
            rd_q <= '0;
            count_q <= '0;
        end else begin
            if (push) wr_q <= next_ptr(wr_q);
            if (pop) rd_q <= next_ptr(rd_q);
            count_q <= (PW + 1)'(count_q + push - pop);
        end
    end

endmodule : two_entry_fifo

// ---- core/rx_link_b.sv ----
// channel b receive shifter, running on the receive link clock
// assumes the link clock runs for at least three edges during reset
module rx_link_b (
    input wire logic rx_shift_clock_b,
    input wire logic reset_sys,
    input wire logic enable_sys,
    input wire logic rx_data_b,
    output logic [7:0] word_q,
    output logic word_toggle_q
);
    logic en_meta_q;
    logic en_q;
    logic rst_meta_q;
    logic rst_q;
    logic [3:0] bit_q;
    logic [7:0] shift_q;
    wire hunting;
    wire start_seen;
    wire last_bit;

    // ------------------------------------------------------------
    // level crossings into the link domain
    // ------------------------------------------------------------
    always_ff @(posedge rx_shift_clock_b) begin
        en_meta_q <= enable_sys;
        en_q <= en_meta_q;
        rst_meta_q <= reset_sys;
        rst_q <= rst_meta_q;
    end

    assign hunting = (bit_q == serial_pkg::COUNT_RESET);
    assign start_seen = hunting && !rx_data_b;
    assign last_bit = (bit_q == serial_pkg::RX_BIT_LAST);

    // one sample per rising edge; gating off drops a partial word
    always_ff @(posedge rx_shift_clock_b) begin
        if (rst_q || !en_q) begin
            bit_q <= serial_pkg::COUNT_RESET;
        end else if (start_seen) begin
            bit_q <= 4'h1;
        end else if (!hunting) begin
            shift_q <= {rx_data_b, shift_q[7:1]};
            bit_q <= last_bit ? serial_pkg::COUNT_RESET : 4'(bit_q + 1'b1);
        end
    end

    // word is held steady for a full frame after the toggle flips
    always_ff @(posedge rx_shift_clock_b) begin
        if (rst_q) begin
            word_q <= serial_pkg::WORD_RESET;
            word_toggle_q <= 1'b0;
        end else if (en_q && last_bit) begin
            word_q <= {rx_data_b, shift_q[7:1]};
            word_toggle_q <= !word_toggle_q;
        end
    end

endmodule : rx_link_b

// ---- core/serial_controller.sv ----
// reset behaviour and modem gating of a two-channel serial controller
// assumes a host that strobes control words in on clk, a modem on the
// pins, and a channel b receive clock arriving from the modem
module serial_controller #(
    parameter int FIFO_DEPTH = serial_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ctrl_write,
    input wire serial_pkg::ctrl_s ctrl_data,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [7:0] tx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic [7:0] rx_data,
    output serial_pkg::status_s status,
    input wire logic carrier_sense_a_n,
    input wire logic carrier_sense_b_n,
    input wire logic clear_to_send_b_n,
    input wire logic rx_shift_clock_b,
    input wire logic rx_data_b,
    input wire logic tx_shift_clock_b,
    output logic line_out_a,
    output logic line_out_b,
    output logic rts_a_n,
    output logic rts_b_n
);

    // ------------------------------------------------------------
    // control state
    // ------------------------------------------------------------
    serial_pkg::ctrl_s ctrl_q;
    logic configured_q;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic car_a_meta_q;
    logic car_a_q;
    logic car_b_meta_q;
    logic car_b_q;
    logic cts_meta_q;
    logic cts_q;
    logic txc_meta_q;
    logic txc_q;
    logic txc_prev_q;
    logic tog_meta_q;
    logic tog_q;
    logic tog_prev_q;

    // ------------------------------------------------------------
    // datapath state
    // ------------------------------------------------------------
    serial_pkg::tx_state_e tx_state_q;
    serial_pkg::tx_state_e tx_state_d;
    logic [9:0] tx_frame_q;
    logic [3:0] tx_bit_q;
    logic line_b_q;
    logic line_a_q;
    logic rts_a_q;
    logic rts_b_q;
    logic rx_valid_q;
    logic [7:0] rx_data_q;
    logic overrun_q;

    logic [7:0] link_word;
    logic link_toggle;
    logic fifo_valid;
    logic [7:0] fifo_data;

    wire carrier_a;
    wire carrier_b;
    wire cts_active;
    wire rx_on_a;
    wire rx_on_b;
    wire txc_fall;
    wire word_arrived;
    wire tx_allowed;
    wire tx_start;
    wire tx_shift;
    wire tx_done;
    wire tx_empty;
    wire rx_take;
    wire rts_b_hold;

    // ------------------------------------------------------------
    // control capture
    // ------------------------------------------------------------
    // a write replaces the whole control word; configured stays set
    // until the next reset, so a zero write still counts as initialised
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_q <= serial_pkg::CTRL_RESET;
            configured_q <= 1'b0;
        end else if (ctrl_write) begin
            ctrl_q <= ctrl_data;
            configured_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // two-stage synchronisers for asynchronous pins
    // ------------------------------------------------------------
    // only the second stage is read by any logic below
    always_ff @(posedge clk) begin
        car_a_meta_q <= carrier_sense_a_n;
        car_a_q <= car_a_meta_q;
        car_b_meta_q <= carrier_sense_b_n;
        car_b_q <= car_b_meta_q;
        cts_meta_q <= clear_to_send_b_n;
        cts_q <= cts_meta_q;
    end

    // transmit clock is sampled, not used as a clock; this limits it
    // to well under a quarter of clk, fine for the modem rates
    always_ff @(posedge clk) begin
        txc_meta_q <= tx_shift_clock_b;
        txc_q <= txc_meta_q;
        txc_prev_q <= txc_q;
    end

    // word-ready toggle from the receive link domain
    always_ff @(posedge clk) begin
        if (reset) begin
            tog_meta_q <= 1'b0;
            tog_q <= 1'b0;
            tog_prev_q <= 1'b0;
        end else begin
            tog_meta_q <= link_toggle;
            tog_q <= tog_meta_q;
            tog_prev_q <= tog_q;
        end
    end

    // ------------------------------------------------------------
    // receive gating
    // ------------------------------------------------------------
    // carrier and cts pins are active low
    assign carrier_a = !car_a_q;
    assign carrier_b = !car_b_q;
    assign cts_active = !cts_q;
    // auto-enable waits for carrier; without it the enable alone rules
    assign rx_on_a = configured_q && ctrl_q.rx_enable_a
        && (!ctrl_q.auto_enable_a || carrier_a);
    assign rx_on_b = configured_q && ctrl_q.rx_enable_b
        && (!ctrl_q.auto_enable_b || carrier_b);

    // ------------------------------------------------------------
    // channel b receiver in its own clock domain
    // ------------------------------------------------------------
    rx_link_b u_rx_link_b (
        .rx_shift_clock_b(rx_shift_clock_b),
        .reset_sys(reset),
        .enable_sys(rx_on_b),
        .rx_data_b(rx_data_b),
        .word_q(link_word),
        .word_toggle_q(link_toggle)
    );

    // the link word is stable for a whole frame after the toggle,
    // so reading it on the synchronised edge is safe
    assign word_arrived = tog_q ^ tog_prev_q;
    assign rx_take = rx_valid_q && rx_ready;

    // receive holding register; a line cannot be stalled, so a word
    // that finds the holder full is dropped and flagged instead
    always_ff @(posedge clk) begin
        if (reset) begin
            rx_valid_q <= 1'b0;
            rx_data_q <= serial_pkg::WORD_RESET;
            overrun_q <= 1'b0;
        end else begin
            if (word_arrived && (!rx_valid_q || rx_take)) begin
                rx_valid_q <= 1'b1;
                rx_data_q <= link_word;
            end else if (rx_take) begin
                rx_valid_q <= 1'b0;
            end
            // set beats a clear by a fresh control write
            if (word_arrived && rx_valid_q && !rx_take) begin
                overrun_q <= 1'b1;
            end else if (ctrl_write) begin
                overrun_q <= 1'b0;
            end
        end
    end

    assign rx_valid = rx_valid_q;
    assign rx_data = rx_data_q;

    // ------------------------------------------------------------
    // transmit buffer
    // ------------------------------------------------------------
    // the host stalls on tx_ready once both entries are taken
    two_entry_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .clk(clk),
        .reset(reset),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .in_data(tx_data),
        .out_valid(fifo_valid),
        .out_ready(tx_start),
        .out_data(fifo_data)
    );

    // ------------------------------------------------------------
    // channel b transmitter
    // ------------------------------------------------------------
    assign txc_fall = txc_prev_q && !txc_q;
    // a byte may start only with cts when auto-enable is on
    assign tx_allowed = configured_q && ctrl_q.tx_enable_b
        && (!ctrl_q.auto_enable_b || cts_active);
    assign tx_start = (tx_state_q == serial_pkg::TX_IDLE)
        && fifo_valid && tx_allowed && txc_fall;
    assign tx_shift = (tx_state_q == serial_pkg::TX_SHIFT) && txc_fall;
    assign tx_done = tx_shift && (tx_bit_q == serial_pkg::TX_FRAME_LAST);
    assign tx_empty = (tx_state_q == serial_pkg::TX_IDLE) && !fifo_valid;

    // transmit sequencer
    always_comb begin
        tx_state_d = tx_state_q;
        unique case (tx_state_q)
            serial_pkg::TX_IDLE: begin
                if (tx_start) tx_state_d = serial_pkg::TX_SHIFT;
            end
            serial_pkg::TX_SHIFT: begin
                if (tx_done) tx_state_d = serial_pkg::TX_IDLE;
            end
        endcase
    end

    // the start bit leaves on the loading falling edge, then one bit
    // per falling edge; a byte under way finishes even if cts drops
    always_ff @(posedge clk) begin
        if (reset) begin
            tx_state_q <= serial_pkg::TX_IDLE;
            tx_frame_q <= '1;
            tx_bit_q <= serial_pkg::COUNT_RESET;
            line_b_q <= serial_pkg::LINE_IDLE;
        end else begin
            tx_state_q <= tx_state_d;
            if (tx_start) begin
                tx_frame_q <= {1'b1, 1'b1, fifo_data};
                tx_bit_q <= 4'h1;
                line_b_q <= 1'b0;
            end else if (tx_shift) begin
                line_b_q <= tx_frame_q[0];
                tx_frame_q <= {1'b1, tx_frame_q[9:1]};
                tx_bit_q <= 4'(tx_bit_q + 1'b1);
            end
        end
    end

    // ------------------------------------------------------------
    // modem control outputs
    // ------------------------------------------------------------
    // in async mode a dropped rts b is held until the transmitter drains; rts a has no hold
    assign rts_b_hold = ctrl_q.async_mode && rts_b_q && !tx_empty;

    always_ff @(posedge clk) begin
        if (reset) begin
            rts_a_q <= 1'b0;
            rts_b_q <= 1'b0;
            line_a_q <= serial_pkg::LINE_IDLE;
        end else begin
            rts_a_q <= configured_q && ctrl_q.rts_a;
            rts_b_q <= configured_q && (ctrl_q.rts_b || rts_b_hold);
            line_a_q <= serial_pkg::LINE_IDLE;
        end
    end

    // outputs are all from flops, so they read high through reset
    assign line_out_a = line_a_q;
    assign line_out_b = line_b_q;
    assign rts_a_n = !rts_a_q;
    assign rts_b_n = !rts_b_q;

    // ------------------------------------------------------------
    // status
    // ------------------------------------------------------------
    assign status.configured = configured_q;
    assign status.rx_on_a = rx_on_a;
    assign status.rx_on_b = rx_on_b;
    assign status.tx_busy_b = !tx_empty;
    assign status.rx_overrun_b = overrun_q;

endmodule : serial_controller

// ---- testbench/serial_controller_monitor.sv ----
// assertions on reset levels, carrier gating and line timing
// assumes it is bound onto serial_controller; all sampled on clk
module serial_controller_monitor #(
    parameter int FIFO_DEPTH = 2
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ctrl_write,
    input wire serial_pkg::ctrl_s ctrl_data,
    input wire logic rx_valid,
    input wire serial_pkg::status_s status,
    input wire logic carrier_sense_a_n,
    input wire logic carrier_sense_b_n,
    input wire logic tx_shift_clock_b,
    input wire logic line_out_a,
    input wire logic line_out_b,
    input wire logic rts_a_n,
    input wire logic rts_b_n
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking dc @(posedge clk);
    endclocking
    serial_pkg::ctrl_s ctl_q;
    logic [2:0] fall_q;
    logic txc_q;
    // shadow of the control word
    always_ff @(posedge clk) begin
        if (reset) ctl_q <= serial_pkg::CTRL_RESET;
        else if (ctrl_write) ctl_q <= ctrl_data;
    end
    // cycles since a transmit clock fall
    always_ff @(posedge clk) begin
        txc_q <= tx_shift_clock_b;
        if (reset) fall_q <= 3'h7;
        else if (txc_q && !tx_shift_clock_b) fall_q <= 3'h0;
        else if (fall_q != 3'h7) fall_q <= fall_q + 3'h1;
    end
    property p_rst_pins;
        reset |=> line_out_a && line_out_b && rts_a_n && rts_b_n;
    endproperty
    a_rst_pins: assert property (p_rst_pins)
        else $error("pins not high in reset");
    property p_rst_idle;
        reset |=> !rx_valid && status == serial_pkg::STATUS_RESET;
    endproperty
    a_rst_idle: assert property (p_rst_idle)
        else $error("state not idle in reset");
    property p_cfg;
        disable iff (reset) ctrl_write |=> status.configured;
    endproperty
    a_cfg: assert property (p_cfg)
        else $error("control write not taken");
    property p_unconf;
        disable iff (reset) !status.configured |-> line_out_b && !rx_valid;
    endproperty
    a_unconf: assert property (p_unconf)
        else $error("activity before configuration");
    // three samples cover the two-stage synchroniser
    property p_gate_b;
        disable iff (reset)
        carrier_sense_b_n [*3] ##0 ctl_q.auto_enable_b |-> !status.rx_on_b;
    endproperty
    a_gate_b: assert property (p_gate_b)
        else $error("receiver b open without carrier");
    property p_open_b;
        disable iff (reset)
        !carrier_sense_b_n [*3] ##0 ctl_q.rx_enable_b |-> status.rx_on_b;
    endproperty
    a_open_b: assert property (p_open_b)
        else $error("receiver b closed with carrier");
    property p_gate_a;
        disable iff (reset)
        carrier_sense_a_n [*3] ##0 ctl_q.auto_enable_a |-> !status.rx_on_a;
    endproperty
    a_gate_a: assert property (p_gate_a)
        else $error("receiver a open without carrier");
    property p_tx_edge;
        disable iff (reset) $changed(line_out_b) |-> fall_q <= 3'h5;
    endproperty
    a_tx_edge: assert property (p_tx_edge)
        else $error("line b moved without a falling clock");
    property p_rts_hold;
        disable iff (reset)
        ctl_q.async_mode && status.tx_busy_b && !$past(rts_b_n) |-> !rts_b_n;
    endproperty
    a_rts_hold: assert property (p_rts_hold)
        else $error("request to send dropped while busy");
endmodule : serial_controller_monitor

bind serial_controller serial_controller_monitor #(
    .FIFO_DEPTH(FIFO_DEPTH)
) mon (
    .clk(clk), .reset(reset), .ctrl_write(ctrl_write),
    .ctrl_data(ctrl_data), .rx_valid(rx_valid), .status(status),
    .carrier_sense_a_n(carrier_sense_a_n),
    .carrier_sense_b_n(carrier_sense_b_n),
    .tx_shift_clock_b(tx_shift_clock_b), .line_out_a(line_out_a),
    .line_out_b(line_out_b), .rts_a_n(rts_a_n), .rts_b_n(rts_b_n)
);

// ---- testbench/modem_model.sv ----
// behavioural modem: carriers, clear to send and both link clocks
// assumes the bench calls one task at a time
module modem_model (
    input wire logic line_out_b,
    output logic carrier_sense_a_n,
    output logic carrier_sense_b_n,
    output logic clear_to_send_b_n,
    output logic rx_shift_clock_b,
    output logic rx_data_b,
    output logic tx_shift_clock_b
);
    timeunit 1ns;
    timeprecision 1ns;
    logic txq[$];
    // clocks stand still between frames
    initial begin
        carrier_sense_a_n = 1'b1;
        carrier_sense_b_n = 1'b1;
        clear_to_send_b_n = 1'b1;
        rx_shift_clock_b = 1'b0;
        rx_data_b = 1'b1;
        tx_shift_clock_b = 1'b1;
    end
    // data changes while the clock is low
    task rx_bits(input logic [12:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            rx_data_b = v[i];
            #40 rx_shift_clock_b = 1'b1;
            #40 rx_shift_clock_b = 1'b0;
        end
    endtask : rx_bits
    // three marks let the enable settle
    task frame(input logic [7:0] b, input logic cd);
        carrier_sense_b_n = !cd;
        #200;
        rx_bits({1'b1, b, 1'b0, 3'h7}, 13);
        #400 carrier_sense_b_n = 1'b1;
    endtask : frame
    task lines(input logic a, input logic b, input logic cts);
        carrier_sense_a_n = !a;
        carrier_sense_b_n = !b;
        clear_to_send_b_n = !cts;
    endtask : lines
    // sample late in each cell
    task tx_run(input int n);
        for (int i = 0; i < n; i++) begin
            #10 tx_shift_clock_b = 1'b0;
            #200 tx_shift_clock_b = 1'b1;
            #190 txq.push_back(line_out_b);
        end
    endtask : tx_run
endmodule : modem_model

// ---- testbench/serial_reset_and_rx_gating_tb.sv ----
// self-checking bench of the serial controller against a modem model
// assumes clk at 20 MHz; receive clock 80 ns, transmit clock 400 ns
module serial_reset_and_rx_gating_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int RST_CYC = 8; // room for three link edges
    localparam int LIMIT = 6000;
    logic clk, reset, ctrl_write, tx_valid, tx_ready, rx_valid, rx_ready;
    logic [7:0] tx_data, rx_data, b, e;
    serial_pkg::ctrl_s ctrl_data;
    serial_pkg::status_s status;
    logic carrier_sense_a_n, carrier_sense_b_n, clear_to_send_b_n;
    logic rx_shift_clock_b, rx_data_b, tx_shift_clock_b;
    logic line_out_a, line_out_b, rts_a_n, rts_b_n;
    logic [31:0] s = 32'h0000_76b9;
    logic [7:0] txe[$];
    int errors = 0;
    int n_compared = 0;
    int cyc = 0;

    serial_controller dut (
        .clk(clk), .reset(reset), .ctrl_write(ctrl_write),
        .ctrl_data(ctrl_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_data(tx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .rx_data(rx_data), .status(status),
        .carrier_sense_a_n(carrier_sense_a_n),
        .carrier_sense_b_n(carrier_sense_b_n),
        .clear_to_send_b_n(clear_to_send_b_n),
        .rx_shift_clock_b(rx_shift_clock_b), .rx_data_b(rx_data_b),
        .tx_shift_clock_b(tx_shift_clock_b), .line_out_a(line_out_a),
        .line_out_b(line_out_b), .rts_a_n(rts_a_n), .rts_b_n(rts_b_n)
    );
    modem_model modem (
        .line_out_b(line_out_b), .carrier_sense_a_n(carrier_sense_a_n),
        .carrier_sense_b_n(carrier_sense_b_n),
        .clear_to_send_b_n(clear_to_send_b_n),
        .rx_shift_clock_b(rx_shift_clock_b), .rx_data_b(rx_data_b),
        .tx_shift_clock_b(tx_shift_clock_b)
    );

    always #25 clk = ~clk;
    // a hang counts as a mismatch
    always @(posedge clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            errors++;
            $display("mismatch at %0t: run did not finish", $time);
            summarize();
        end
    end

    function automatic logic [7:0] rnd();
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s[7:0];
    endfunction : rnd
    // receive enable is set in every gating case
    function automatic logic on_exp(input logic a, input logic cd);
        return !a || cd;
    endfunction : on_exp
    task chk(input logic [7:0] g, input logic [7:0] x, input string m);
        n_compared++;
        if (g !== x) begin
            errors++;
            $display("mismatch at %0t: %s got %h want %h", $time, m, g, x);
        end
    endtask : chk
    task wcyc(input int n);
        repeat (n) @(negedge clk);
    endtask : wcyc
    task done(input string t);
        $display("test %s finished", t);
    endtask : done
    task rst_chk();
        chk({6'h0, line_out_a, line_out_b}, 8'h03, "lines");
        chk({6'h0, rts_a_n, rts_b_n}, 8'h03, "modem outs");
        chk({2'h0, rx_valid, status}, 8'h00, "state");
    endtask : rst_chk
    // link clock runs while reset is held
    task do_reset();
        fork
            modem.rx_bits(13'h1fff, 4);
            wcyc(RST_CYC);
        join
        rst_chk();
        reset = 1'b0;
        modem.txq.delete();
    endtask : do_reset
    task ctl(input logic [7:0] v);
        ctrl_data = serial_pkg::ctrl_s'(v);
        ctrl_write = 1'b1;
        @(negedge clk);
        ctrl_write = 1'b0;
        @(negedge clk);
    endtask : ctl
    // random bytes until n taken or refused
    task fill(input int n);
        for (int i = 0; i < n && tx_ready === 1'b1; i++) begin
            tx_data = rnd();
            tx_valid = 1'b1;
            @(negedge clk);
            txe.push_back(tx_data);
        end
        tx_valid = 1'b0;
    endtask : fill
    task txr(input int n);
        modem.tx_run(n);
        @(negedge clk);
    endtask : txr
    task frm(input logic [7:0] v, input logic cd);
        modem.frame(v, cd);
        @(negedge clk);
    endtask : frm
    task idle_line();
        while (modem.txq.size() > 0)
            chk({7'h0, modem.txq.pop_front()}, 8'h01, "idle line");
    endtask : idle_line
    // frame: start 0, lsb first, stop 1
    task drain();
        while (txe.size() > 0) begin
            while (modem.txq.size() > 0 && modem.txq[0] === 1'b1)
                void'(modem.txq.pop_front());
            if (modem.txq.size() < 10) begin
                chk(8'h00, 8'h01, "frame missing");
                txe.delete();
            end else begin
                void'(modem.txq.pop_front());
                for (int i = 0; i < 8; i++) b[i] = modem.txq.pop_front();
                chk(b, txe.pop_front(), "line byte");
                chk({7'h0, modem.txq.pop_front()}, 8'h01, "stop");
            end
        end
        modem.txq.delete();
    endtask : drain
    task rx_get(input logic [7:0] x);
        for (int k = 0; k < 60 && rx_valid !== 1'b1; k++) @(negedge clk);
        chk({7'h0, rx_valid}, 8'h01, "rx valid");
        chk(rx_data, x, "rx byte");
        rx_ready = 1'b1;
        @(negedge clk);
        rx_ready = 1'b0;
    endtask : rx_get
    task summarize();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize

    initial begin
        clk = 1'b0;
        reset = 1'b1;
        ctrl_write = 1'b0;
        ctrl_data = serial_pkg::CTRL_RESET;
        tx_valid = 1'b0;
        tx_data = 8'h00;
        rx_ready = 1'b0;
        do_reset();
        // idle before first control write
        fill(1);
        txr(12);
        idle_line();
        frm(rnd(), 1'b1);
        chk({7'h0, rx_valid}, 8'h00, "rx unconfigured");
        ctl(8'h04);
        txr(12);
        drain();
        // auto-enable waits for cts
        ctl(8'h24);
        fill(1);
        txr(12);
        idle_line();
        modem.lines(1'b0, 1'b0, 1'b1);
        txr(12);
        drain();
        // stalled clock: fill until refused
        fill(8);
        chk({7'h0, tx_ready}, 8'h00, "buffer full");
        txr(txe.size() * 10 + 4);
        drain();
        done("transmit");
        for (int i = 0; i < 4; i++) begin
            ctl({1'b0, i[1], i[1], 2'h3, 3'h0});
            modem.lines(i[0], i[0], 1'b1);
            wcyc(5);
            e = {7'h0, on_exp(i[1], i[0])};
            chk({7'h0, status.rx_on_a}, e, "gate a");
            chk({7'h0, status.rx_on_b}, e, "gate b");
        end
        modem.lines(1'b0, 1'b0, 1'b1);
        frm(rnd(), 1'b0);
        chk({7'h0, rx_valid}, 8'h00, "no carrier");
        b = rnd();
        frm(b, 1'b1);
        rx_get(b);
        // second word while held is lost
        e = rnd();
        frm(e, 1'b1);
        frm(rnd(), 1'b1);
        chk({7'h0, status.rx_overrun_b}, 8'h01, "overrun");
        rx_get(e);
        done("receive");
        ctl(8'h87);
        wcyc(3);
        chk({6'h0, rts_a_n, rts_b_n}, 8'h00, "rts on");
        fill(1);
        ctl(8'h84);
        wcyc(4);
        chk({6'h0, rts_b_n, status.tx_busy_b}, 8'h01, "rts held");
        txr(12);
        drain();
        wcyc(3);
        chk({6'h0, rts_b_n, status.tx_busy_b}, 8'h02, "rts off");
        done("rts");
        // reset mid-frame
        ctl(8'h87);
        fill(1);
        txr(3);
        reset = 1'b1;
        do_reset();
        txe.delete();
        fill(1);
        txr(12);
        idle_line();
        done("reset");
        summarize();
    end
endmodule : serial_reset_and_rx_gating_tb
